// ===== include/gpt_pkg.sv
// Constants for the general-purpose up/down timer with capture.
// Assumes an APB master on pclk at 100 MHz and pins synchronised in rtl.
package gpt_pkg;
  localparam logic [31:0] ADDR_LOAD = 32'h4000_0800;
  localparam logic [31:0] ADDR_VALUE = 32'h4000_0804;
  localparam logic [31:0] ADDR_CTRL = 32'h4000_0808;
  localparam logic [31:0] ADDR_CLEAR = 32'h4000_080c;
  localparam logic [31:0] ADDR_CAPT = 32'h4000_0810;
  localparam logic [31:0] ADDR_STATUS = 32'h4000_081c;
  localparam logic [31:0] ADDR_IRQ_EN = 32'h4000_0820;
  localparam logic [15:0] CTRL_RESET = 16'h000a;
  localparam logic [15:0] CTRL_MASK = 16'h1fff;
  localparam int CTRL_PRE_LSB = 0;
  localparam int CTRL_UP = 2;
  localparam int CTRL_PERIODIC = 3;
  localparam int CTRL_ENABLE = 4;
  localparam int CTRL_CLK_LSB = 5;
  localparam int CTRL_RELOAD = 7;
  localparam int CTRL_EVT_LSB = 8;
  localparam int CTRL_CAP_EN = 12;
  localparam int CLR_TIMEOUT = 0;
  localparam int CLR_CAPTURE = 1;
  localparam int STA_TIMEOUT = 0;
  localparam int STA_CAPTURE = 1;
  localparam int STA_BUSY = 6;
  localparam int STA_CLR_SYNC = 7;
  localparam logic [1:0] SRC_PCLK = 2'h0;
  localparam logic [1:0] SRC_HCLK = 2'h1;
  localparam logic [1:0] SRC_LOW_FREQ = 2'h2;
  localparam logic [1:0] SRC_HFSRC = 2'h3;
  // Prescaler terminal counts, divisor minus one
  localparam logic [14:0] DIV1_LAST = 15'h0000;
  localparam logic [14:0] DIV4_LAST = 15'h0003;
  localparam logic [14:0] DIV16_LAST = 15'h000f;
  localparam logic [14:0] DIV256_LAST = 15'h00ff;
  localparam logic [14:0] DIV32K_LAST = 15'h7fff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_FULL = 16'hffff;
  localparam logic [15:0] LOAD_RESET = 16'h0000;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;
  // Control and clear crossing time into the timer side
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SYNC_NS = 20;
  localparam int SYNC_CYC_I = (SYNC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] SYNC_LAST = 2'(SYNC_CYC_I - 1);
endpackage : gpt_pkg

// ===== include/gpt_tick_if.sv
// Carrier between the timer core and its prescaler.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface gpt_tick_if;
  logic [1:0] clk_sel;
  logic [1:0] pre;
  logic run;
  logic tick;
  modport src (input clk_sel, input pre, input run, output tick);
  modport sink (output clk_sel, output pre, output run, input tick);
endinterface : gpt_tick_if

// ===== rtl/gpt_prescaler.sv
// Clock source select and prescaler, giving one count enable pulse.
// Assumes oscillator inputs are slow against pclk; edges are sampled.
`timescale 1ns/1ps
module gpt_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic low_freq_oscillator,
  input wire logic hfsrc_clk,
  gpt_tick_if.src tk
);
  logic [2:0] lf_ff, nxt_lf;
  logic [2:0] hf_ff, nxt_hf;
  logic [14:0] pcnt_ff, nxt_pcnt;
  logic src_en;
  logic [14:0] last;

  // Terminal count from code and source
  function automatic logic [14:0] div_last(input logic [1:0] pre, input logic [1:0] sel);
    case (pre)
      2'h0: div_last = (sel == gpt_pkg::SRC_PCLK || sel == gpt_pkg::SRC_HCLK) ?
                       gpt_pkg::DIV4_LAST : gpt_pkg::DIV1_LAST;
      2'h1: div_last = gpt_pkg::DIV16_LAST;
      2'h2: div_last = gpt_pkg::DIV256_LAST;
      default: div_last = gpt_pkg::DIV32K_LAST;
    endcase
  endfunction : div_last

  // Two stage sync, third stage only for the edge
  always_comb begin
    nxt_lf = {lf_ff[1:0], low_freq_oscillator};
    nxt_hf = {hf_ff[1:0], hfsrc_clk};
    last = div_last(tk.pre, tk.clk_sel);
    // Bus clocks run at pclk rate here, so they enable every cycle
    case (tk.clk_sel)
      gpt_pkg::SRC_PCLK: src_en = 1'b1;
      gpt_pkg::SRC_HCLK: src_en = 1'b1;
      gpt_pkg::SRC_LOW_FREQ: src_en = lf_ff[1] & ~lf_ff[2];
      default: src_en = hf_ff[1] & ~hf_ff[2];
    endcase
    tk.tick = tk.run & src_en & (pcnt_ff >= last);
    if (!tk.run) begin
      nxt_pcnt = 15'h0000;
    end else if (tk.tick) begin
      nxt_pcnt = 15'h0000;
    end else if (src_en) begin
      nxt_pcnt = pcnt_ff + 15'h0001;
    end else begin
      nxt_pcnt = pcnt_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_ff <= 3'h0;
      hf_ff <= 3'h0;
      pcnt_ff <= 15'h0000;
    end else begin
      lf_ff <= nxt_lf;
      hf_ff <= nxt_hf;
      pcnt_ff <= nxt_pcnt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_div4_run;
    tk.tick && tk.run && tk.pre == 2'h0 && tk.clk_sel == gpt_pkg::SRC_PCLK;
  endsequence
  AST_DIV4_PERIOD: assert property (s_div4_run |=> (!tk.tick)[*3] ##1
    (tk.tick || !tk.run || tk.pre != 2'h0 || tk.clk_sel != gpt_pkg::SRC_PCLK))
    else $error("bus clock code 0 does not divide by four");
  AST_LF_DIV1: assert property (tk.run && src_en && tk.pre == 2'h0 &&
    tk.clk_sel == gpt_pkg::SRC_LOW_FREQ |-> tk.tick)
    else $error("slow source code 0 does not divide by one");
endmodule : gpt_prescaler

// ===== rtl/gpt_timer.sv
// Up/down timer with capture, status and interrupt, on an APB slave.
// Assumes pclk at 100 MHz, synchronous APB master, async event pins.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module gpt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_freq_oscillator,
  input wire logic hfsrc_clk,
  input wire logic [15:0] event_in,
  output logic timer_irq
);
  typedef enum logic {GPT_XS_IDLE, GPT_XS_BUSY} gpt_xs_e;

  gpt_tick_if tk ();

  gpt_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .low_freq_oscillator(low_freq_oscillator),
    .hfsrc_clk(hfsrc_clk),
    .tk(tk)
  );

  // Bus side registers
  logic [15:0] load_ff, nxt_load;
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic [1:0] irq_en_ff, nxt_irq_en;
  logic [31:0] prdata_ff, nxt_prdata;
  // Crossing state
  gpt_xs_e xs_ff, nxt_xs;
  logic [1:0] xcnt_ff, nxt_xcnt;
  logic [15:0] act_ff, nxt_act;
  logic clr_pend_ff, nxt_clr_pend;
  logic [1:0] ccnt_ff, nxt_ccnt;
  // Timer side
  logic [15:0] count_ff, nxt_count;
  logic run_d_ff, nxt_run_d;
  logic tmo_ff, nxt_tmo;
  logic cap_pend_ff, nxt_cap_pend;
  logic [15:0] cap_ff, nxt_cap;
  logic [15:0] ev_s1_ff, ev_s2_ff, ev_d_ff;

  logic wr_en, rd_setup, hit;
  logic ctrl_wr, clr_tmo_wr, clr_cap_wr;
  logic clr_fire, act_apply, start, tmo_evt, cap_evt;
  logic act_en, act_up, act_per;
  logic [15:0] restart_val;
  logic [15:0] status;

  // Address decode shared by read and write paths
  function automatic logic addr_hit(input logic [31:0] a);
    case (a)
      gpt_pkg::ADDR_LOAD, gpt_pkg::ADDR_VALUE, gpt_pkg::ADDR_CTRL,
      gpt_pkg::ADDR_CLEAR, gpt_pkg::ADDR_CAPT, gpt_pkg::ADDR_STATUS,
      gpt_pkg::ADDR_IRQ_EN: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  // Zero wait state slave; unmapped addresses answer with an error
  assign hit = addr_hit(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_ff;
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign ctrl_wr = wr_en && paddr == gpt_pkg::ADDR_CTRL;
  assign clr_tmo_wr = wr_en && paddr == gpt_pkg::ADDR_CLEAR &&
                      pwdata[gpt_pkg::CLR_TIMEOUT];
  assign clr_cap_wr = wr_en && paddr == gpt_pkg::ADDR_CLEAR &&
                      pwdata[gpt_pkg::CLR_CAPTURE];

  // Timer side view of the control fields
  assign act_en = act_ff[gpt_pkg::CTRL_ENABLE];
  assign act_up = act_ff[gpt_pkg::CTRL_UP];
  assign act_per = act_ff[gpt_pkg::CTRL_PERIODIC];
  assign tk.run = act_en;
  assign tk.pre = act_ff[gpt_pkg::CTRL_PRE_LSB +: 2];
  assign tk.clk_sel = act_ff[gpt_pkg::CTRL_CLK_LSB +: 2];

  // Status word as software sees it
  always_comb begin
    status = 16'h0000;
    status[gpt_pkg::STA_TIMEOUT] = tmo_ff;
    status[gpt_pkg::STA_CAPTURE] = cap_pend_ff;
    status[gpt_pkg::STA_BUSY] = (xs_ff == GPT_XS_BUSY);
    status[gpt_pkg::STA_CLR_SYNC] = clr_pend_ff;
  end

  assign timer_irq = |(status[1:0] & irq_en_ff);

  // Bus registers; read data is sampled in setup so it is stable in access
  always_comb begin
    nxt_load = load_ff;
    nxt_ctrl = ctrl_ff;
    nxt_irq_en = irq_en_ff;
    nxt_prdata = prdata_ff;
    if (wr_en && paddr == gpt_pkg::ADDR_LOAD) begin
      nxt_load = pwdata[15:0];
    end
    if (ctrl_wr) begin
      nxt_ctrl = pwdata[15:0] & gpt_pkg::CTRL_MASK;
    end
    if (wr_en && paddr == gpt_pkg::ADDR_IRQ_EN) begin
      nxt_irq_en = pwdata[1:0];
    end
    if (rd_setup) begin
      case (paddr)
        gpt_pkg::ADDR_LOAD: nxt_prdata = {16'h0000, load_ff};
        gpt_pkg::ADDR_VALUE: nxt_prdata = {16'h0000, count_ff};
        gpt_pkg::ADDR_CTRL: nxt_prdata = {16'h0000, ctrl_ff};
        gpt_pkg::ADDR_CAPT: nxt_prdata = {16'h0000, cap_ff};
        gpt_pkg::ADDR_STATUS: nxt_prdata = {16'h0000, status};
        gpt_pkg::ADDR_IRQ_EN: nxt_prdata = {30'h0, irq_en_ff};
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_ff <= gpt_pkg::LOAD_RESET;
      ctrl_ff <= gpt_pkg::CTRL_RESET;
      irq_en_ff <= gpt_pkg::IRQ_EN_RESET;
      prdata_ff <= 32'h0000_0000;
    end else begin
      load_ff <= nxt_load;
      ctrl_ff <= nxt_ctrl;
      irq_en_ff <= nxt_irq_en;
      prdata_ff <= nxt_prdata;
    end
  end

  // Control and timeout-clear crossings; a new control write restarts the wait
  always_comb begin
    nxt_xs = xs_ff;
    nxt_xcnt = xcnt_ff;
    nxt_act = act_ff;
    act_apply = 1'b0;
    case (xs_ff)
      GPT_XS_IDLE: begin
        if (ctrl_wr) begin
          nxt_xs = GPT_XS_BUSY;
          nxt_xcnt = gpt_pkg::SYNC_LAST;
        end
      end
      GPT_XS_BUSY: begin
        if (ctrl_wr) begin
          nxt_xcnt = gpt_pkg::SYNC_LAST;
        end else if (xcnt_ff == 2'h0) begin
          nxt_xs = GPT_XS_IDLE;
          act_apply = 1'b1;
          nxt_act = ctrl_ff;
        end else begin
          nxt_xcnt = xcnt_ff - 2'h1;
        end
      end
      default: nxt_xs = GPT_XS_IDLE;
    endcase
    clr_fire = clr_pend_ff && ccnt_ff == 2'h0 && !clr_tmo_wr;
    nxt_clr_pend = clr_pend_ff;
    nxt_ccnt = ccnt_ff;
    if (clr_tmo_wr) begin
      nxt_clr_pend = 1'b1;
      nxt_ccnt = gpt_pkg::SYNC_LAST;
    end else if (clr_fire) begin
      nxt_clr_pend = 1'b0;
    end else if (clr_pend_ff) begin
      nxt_ccnt = ccnt_ff - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xs_ff <= GPT_XS_IDLE;
      xcnt_ff <= 2'h0;
      act_ff <= gpt_pkg::CTRL_RESET;
      clr_pend_ff <= 1'b0;
      ccnt_ff <= 2'h0;
    end else begin
      xs_ff <= nxt_xs;
      xcnt_ff <= nxt_xcnt;
      act_ff <= nxt_act;
      clr_pend_ff <= nxt_clr_pend;
      ccnt_ff <= nxt_ccnt;
    end
  end

  // Counter, timeout and capture
  always_comb begin
    nxt_run_d = act_en;
    start = act_en & ~run_d_ff;
    if (act_per) begin
      restart_val = load_ff;
    end else begin
      restart_val = act_up ? gpt_pkg::COUNT_ZERO : gpt_pkg::COUNT_FULL;
    end
    tmo_evt = 1'b0;
    if (!act_en) begin
      nxt_count = gpt_pkg::COUNT_RESET;
    end else if (start) begin
      nxt_count = restart_val;
    end else if (clr_fire && act_per && act_ff[gpt_pkg::CTRL_RELOAD]) begin
      nxt_count = load_ff;
    end else if (tk.tick) begin
      if (act_up ? count_ff == gpt_pkg::COUNT_FULL : count_ff == gpt_pkg::COUNT_ZERO) begin
        tmo_evt = 1'b1;
        nxt_count = restart_val;
      end else if (act_up) begin
        nxt_count = count_ff + 16'h0001;
      end else begin
        nxt_count = count_ff - 16'h0001;
      end
    end else begin
      nxt_count = count_ff;
    end
    // A timeout in the cycle of the clear still sets the flag
    if (tmo_evt) begin
      nxt_tmo = 1'b1;
    end else if (clr_fire) begin
      nxt_tmo = 1'b0;
    end else begin
      nxt_tmo = tmo_ff;
    end
    cap_evt = act_ff[gpt_pkg::CTRL_CAP_EN] &
              ev_s2_ff[act_ff[gpt_pkg::CTRL_EVT_LSB +: 4]] &
              ~ev_d_ff[act_ff[gpt_pkg::CTRL_EVT_LSB +: 4]];
    nxt_cap = cap_ff;
    nxt_cap_pend = cap_pend_ff;
    // Pending value is locked; a clear in the same cycle frees it
    if (cap_evt && (!cap_pend_ff || clr_cap_wr)) begin
      nxt_cap = count_ff;
      nxt_cap_pend = 1'b1;
    end else if (clr_cap_wr) begin
      nxt_cap_pend = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= gpt_pkg::COUNT_RESET;
      run_d_ff <= 1'b0;
      tmo_ff <= 1'b0;
      cap_pend_ff <= 1'b0;
      cap_ff <= 16'h0000;
      ev_s1_ff <= 16'h0000;
      ev_s2_ff <= 16'h0000;
      ev_d_ff <= 16'h0000;
    end else begin
      count_ff <= nxt_count;
      run_d_ff <= nxt_run_d;
      tmo_ff <= nxt_tmo;
      cap_pend_ff <= nxt_cap_pend;
      cap_ff <= nxt_cap;
      ev_s1_ff <= event_in;
      ev_s2_ff <= ev_s1_ff;
      ev_d_ff <= ev_s2_ff;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_plain_tick;
    act_en && run_d_ff && !clr_fire && tk.tick;
  endsequence
  sequence s_ctrl_cross;
    ctrl_wr ##1 (!ctrl_wr)[*2];
  endsequence

  AST_COUNT_DOWN: assert property (s_plain_tick and !act_up &&
    count_ff != 16'h0000 |=> count_ff == $past(count_ff) - 16'h0001)
    else $error("down count did not decrement");
  AST_COUNT_UP: assert property (s_plain_tick and act_up &&
    count_ff != 16'hffff |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("up count did not increment");
  AST_TMO_SET: assert property (s_plain_tick and !act_up &&
    count_ff == 16'h0000 |=> tmo_ff)
    else $error("timeout flag not set at zero");
  AST_WRAP_FREE: assert property (s_plain_tick and act_up && !act_per &&
    count_ff == 16'hffff |=> count_ff == 16'h0000)
    else $error("free running up count did not wrap");
  AST_START_LOAD: assert property (start && act_per |=>
    count_ff == $past(load_ff))
    else $error("periodic start not at load value");
  AST_DISABLED: assert property (!act_en |=> count_ff == 16'h0000)
    else $error("disabled timer holds a count");
  AST_BUSY_CROSS: assert property (s_ctrl_cross |-> status[6] && act_apply ##1
    (!status[6] && act_ff == ctrl_ff))
    else $error("control crossing timing wrong");
  AST_CLR_SYNC: assert property (clr_tmo_wr |=> clr_pend_ff ##[1:3]
    (!clr_pend_ff || clr_tmo_wr))
    else $error("timeout clear crossing did not finish");
  AST_TMO_CLR: assert property (clr_fire && !tmo_evt |=> !tmo_ff)
    else $error("timeout flag survived its clear");
  AST_CAP_HOLD: assert property (cap_pend_ff && !clr_cap_wr |=>
    $stable(cap_ff) && cap_pend_ff)
    else $error("captured value overwritten while pending");
  AST_CAP_TAKE: assert property (cap_evt && !cap_pend_ff |=>
    cap_ff == $past(count_ff) && status[1])
    else $error("capture did not copy the count");
  AST_CAP_CLR: assert property (clr_cap_wr && !cap_evt |=> !status[1])
    else $error("capture clear had no effect");
endmodule : gpt_timer

// ===== verification/gp_timer_capture_status_test.sv
// Self-checking bench for the up/down timer with capture and status flags.
// Assumes gpt_pkg and gpt_timer are compiled first; pclk 100 MHz, APB master here.
`timescale 1ns/1ps
module gp_timer_capture_status_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic low_freq_oscillator = 1'b0;
  logic hfsrc_clk = 1'b0;
  logic [15:0] event_in = 16'h0000;
  logic timer_irq;
  logic [7:0] osc_cnt = 8'h00;
  int n_fail = 0;
  int check_count = 0;

  // Bus clock
  always #5 pclk = ~pclk;

  // Slow source pins: low source period 16 cycles, high source period 4
  always @(posedge pclk) begin
    osc_cnt <= osc_cnt + 8'h01;
    low_freq_oscillator <= osc_cnt[3];
    hfsrc_clk <= osc_cnt[1];
  end

  gpt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_freq_oscillator(low_freq_oscillator), .hfsrc_clk(hfsrc_clk),
    .event_in(event_in), .timer_irq(timer_irq));

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {16'h0000, d}, q, e);
  endtask : wr

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // Control write, then poll the busy flag; reports whether the first poll saw it set
  task automatic ctrl_wr(input logic [15:0] c, output logic sb);
    logic [31:0] s;
    int n;
    n = 0;
    wr(gpt_pkg::ADDR_CTRL, c);
    rd(gpt_pkg::ADDR_STATUS, s);
    sb = s[6];
    while (s[6] !== 1'b0 && n < 10) begin
      rd(gpt_pkg::ADDR_STATUS, s);
      n++;
    end
    if (n >= 10) begin
      n_fail++;
      conclude();
    end
  endtask : ctrl_wr

  // Short pulse on one capture event pin
  task automatic pulse(input int k);
    @(posedge pclk);
    event_in <= 16'h0001 << k;
    idle(4);
    event_in <= 16'h0000;
    idle(6);
  endtask : pulse

  task automatic t_reset;
    logic [31:0] a[5] = '{gpt_pkg::ADDR_LOAD, gpt_pkg::ADDR_VALUE, gpt_pkg::ADDR_CAPT,
                          gpt_pkg::ADDR_STATUS, gpt_pkg::ADDR_IRQ_EN};
    logic [31:0] q;
    logic e;
    logic b;
    rd(gpt_pkg::ADDR_CTRL, q);
    chk(q, {16'h0000, gpt_pkg::CTRL_RESET});
    foreach (a[i]) begin
      rd(a[i], q);
      chk(q, 32'h0000_0000);
    end
    chk(32'(timer_irq), 32'h1 - 32'h1);
    apb(1'b0, 32'h4000_0814, 32'h0, q, e);
    chk(q, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    ctrl_wr(gpt_pkg::CTRL_RESET, b);
    chk(32'(b), 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset

  // Every prescale code, every source, both directions, by counting ticks
  task automatic t_prescale;
    logic [15:0] ctl[8] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013,
                            16'h0030, 16'h0050, 16'h0070, 16'h0014};
    int dv[8] = '{4, 16, 256, 32768, 4, 16, 4, 4};
    int nt[8] = '{8, 4, 2, 1, 8, 4, 8, 8};
    logic [31:0] v1;
    logic [31:0] v2;
    logic b;
    logic up;
    int d;
    foreach (ctl[i]) begin
      ctrl_wr(16'h0000, b);
      ctrl_wr(ctl[i], b);
      up = ctl[i][2];
      rd(gpt_pkg::ADDR_VALUE, v1);
      chk(32'(up ? v1[15:0] < 16'h0100 : v1[15:0] > 16'hff00), 32'h1);
      idle(dv[i] * nt[i]);
      rd(gpt_pkg::ADDR_VALUE, v2);
      d = up ? int'(v2[15:0]) - int'(v1[15:0]) : int'(v1[15:0]) - int'(v2[15:0]);
      chk(32'(d >= nt[i] && d <= nt[i] + 1), 32'h1);
    end
    $display("test prescale done");
  endtask : t_prescale

  // Timeout in both directions, interrupt masking, timeout clear crossing
  task automatic t_timeout;
    logic [31:0] s;
    logic [31:0] v;
    logic b;
    logic seen;
    int n;
    wr(gpt_pkg::ADDR_LOAD, 16'h0040);
    ctrl_wr(16'h0000, b);
    // Periodic down count with reload on timeout clear
    ctrl_wr(16'h0098, b);
    idle(300);
    rd(gpt_pkg::ADDR_STATUS, s);
    chk(32'(s[0]), 32'h1);
    rd(gpt_pkg::ADDR_VALUE, v);
    chk(32'(v <= 32'h40), 32'h1);
    wr(gpt_pkg::ADDR_IRQ_EN, 16'h0001);
    idle(1);
    chk(32'(timer_irq), 32'h1);
    wr(gpt_pkg::ADDR_IRQ_EN, 16'h0000);
    idle(1);
    chk(32'(timer_irq), 32'h0);
    wr(gpt_pkg::ADDR_IRQ_EN, 16'h0001);
    wr(gpt_pkg::ADDR_CLEAR, 16'h0000);
    rd(gpt_pkg::ADDR_STATUS, s);
    chk(32'(s[0]), 32'h1);
    wr(gpt_pkg::ADDR_CLEAR, 16'h0001);
    seen = 1'b0;
    n = 0;
    do begin
      rd(gpt_pkg::ADDR_STATUS, s);
      if (s[7] === 1'b1) seen = 1'b1;
      n++;
    end while (s[7] !== 1'b0 && n < 6);
    chk(32'(seen), 32'h1);
    chk({24'h0, s[7:0]} & 32'h81, 32'h0);
    chk(32'(timer_irq), 32'h0);
    // The clear reached the timer side and reloaded the count from the load value
    rd(gpt_pkg::ADDR_VALUE, v);
    chk(32'(v >= 32'h38 && v <= 32'h40), 32'h1);
    // Up count from a high load reaches full scale quickly
    wr(gpt_pkg::ADDR_LOAD, 16'hffc0);
    ctrl_wr(16'h0000, b);
    ctrl_wr(16'h001c, b);
    rd(gpt_pkg::ADDR_STATUS, s);
    chk(32'(s[0]), 32'h0);
    idle(300);
    rd(gpt_pkg::ADDR_STATUS, s);
    chk(32'(s[0]), 32'h1);
    rd(gpt_pkg::ADDR_VALUE, v);
    chk(32'(v >= 32'hffc0), 32'h1);
    wr(gpt_pkg::ADDR_IRQ_EN, 16'h0000);
    $display("test timeout done");
  endtask : t_timeout

  // Capture hold, capture clear, unselected pin, then disable
  task automatic t_capture;
    logic [31:0] c1;
    logic [31:0] c2;
    logic [31:0] v;
    logic [31:0] s;
    logic b;
    ctrl_wr(16'h0000, b);
    ctrl_wr(16'h1310, b);
    wr(gpt_pkg::ADDR_IRQ_EN, 16'h0002);
    pulse(3);
    rd(gpt_pkg::ADDR_CAPT, c1);
    rd(gpt_pkg::ADDR_VALUE, v);
    rd(gpt_pkg::ADDR_STATUS, s);
    chk(32'(s[1]), 32'h1);
    chk(32'(c1 > v && c1 - v < 32'd40), 32'h1);
    chk(32'(timer_irq), 32'h1);
    pulse(3);
    rd(gpt_pkg::ADDR_CAPT, c2);
    chk(c2, c1);
    wr(gpt_pkg::ADDR_CLEAR, 16'h0000);
    rd(gpt_pkg::ADDR_STATUS, s);
    chk(32'(s[1]), 32'h1);
    wr(gpt_pkg::ADDR_CLEAR, 16'h0002);
    rd(gpt_pkg::ADDR_STATUS, s);
    chk(32'(s[1]), 32'h0);
    chk(32'(timer_irq), 32'h0);
    pulse(2);
    rd(gpt_pkg::ADDR_STATUS, s);
    chk(32'(s[1]), 32'h0);
    pulse(3);
    rd(gpt_pkg::ADDR_CAPT, c2);
    chk(32'(c2 < c1), 32'h1);
    ctrl_wr(16'h0000, b);
    rd(gpt_pkg::ADDR_VALUE, v);
    chk(v, 32'h0000_0000);
    $display("test capture done");
  endtask : t_capture

  // Reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prescale();
    t_timeout();
    t_capture();
    conclude();
  end
endmodule : gp_timer_capture_status_test
